// File: design/umcl_regs.svh
// Register offsets, field positions and reset values of the modem
// control and loopback block. Assumes a 32-bit APB with byte addresses.
`ifndef UMCL_REGS_SVH
`define UMCL_REGS_SVH

`define UMCL_OFF_MLC 8'h00
`define UMCL_OFF_MLS 8'h04
`define UMCL_OFF_IER 8'h08
`define UMCL_OFF_IST 8'h0c
`define UMCL_OFF_IMSK 8'h10

`define UMCL_MLC_DTR 0
`define UMCL_MLC_RTS 1
`define UMCL_MLC_OUT 2
`define UMCL_MLC_IEN 3
`define UMCL_MLC_LOOP 4

`define UMCL_MLS_DCTS 0
`define UMCL_MLS_DDSR 1
`define UMCL_MLS_TERI 2
`define UMCL_MLS_DDCD 3

`define UMCL_IRQ_RXD 0
`define UMCL_IRQ_THRE 1
`define UMCL_IRQ_LINE 2
`define UMCL_IRQ_MODEM 3

`define UMCL_MLC_RST 5'h00
`define UMCL_IER_RST 4'h0
`define UMCL_IST_RST 4'h0
`define UMCL_IMSK_RST 4'h0

`endif

// File: design/umcl_pkg.sv
// Types shared by the modem control and loopback block.
// Assumes nothing of its surroundings.
package umcl_pkg;
  typedef logic [7:0] umcl_byte_t;
  typedef logic [3:0] umcl_nib_t;
  typedef logic [31:0] umcl_word_t;
endpackage : umcl_pkg

// File: design/umcl_top.sv
// Modem control register, modem status register and local loopback
// of a serial port, with APB register access and one interrupt line.
// Assumes all pins and event inputs are synchronous to pclk, and that
// the transmitter and receiver shift registers live outside this block.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "umcl_regs.svh"

// Function
// - In loopback the serial transmit pin stays at mark, logic one.
// - In loopback the external serial receive pin is ignored.
// - In loopback transmit shifter output feeds receive shifter input.
// - In loopback modem inputs are cut off; control bits replace them.
// - In loopback modem control output pins are forced high.
// - Receiver and transmitter interrupt status keeps working in loopback.
// - In loopback modem status changes come from control bits 3..0.
// - All interrupt kinds stay gated by the interrupt enable register.
// - Control bit 3 enables the interrupt output; clear keeps it low.
// - In loopback control bit 3 shows as status bit 7.
// - Control bit 2 is a general bit; outside loopback it is only written and read back.
// - In loopback control bit 2 shows as status bit 6.
// - Control bit 1 drives request-to-send; loopback shows it as bit 4.
// - Control bit 0 set drives terminal ready low, clear drives it high.
// - In loopback control bit 0 shows as status bit 5.
// - Delta bits set on input change (ring only on its trailing edge), cleared by reading status.
module umcl_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  input wire logic clear_to_send_n,
  input wire logic data_set_ready_n,
  input wire logic ring_indicate_n,
  input wire logic carrier_detect_n,
  output logic terminal_ready_n,
  output logic request_to_send_n,
  input wire logic tx_shift_out,
  output logic rx_shift_in,
  input wire logic rx_data_event,
  input wire logic tx_empty_event,
  input wire logic line_status_event,
  output logic uart_irq
);

  logic [4:0] modem_line_control_r;
  umcl_pkg::umcl_nib_t interrupt_enable_reg_r;
  umcl_pkg::umcl_nib_t irq_status_r;
  umcl_pkg::umcl_nib_t irq_mask_r;
  umcl_pkg::umcl_nib_t delta_r;
  umcl_pkg::umcl_nib_t line_prev_r;
  umcl_pkg::umcl_nib_t line_now;
  umcl_pkg::umcl_nib_t delta_set;
  umcl_pkg::umcl_byte_t modem_line_status;
  umcl_pkg::umcl_nib_t irq_events;
  umcl_pkg::umcl_word_t rd_data;
  logic loop_en;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic addr_ok;

  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  assign loop_en = modem_line_control_r[`UMCL_MLC_LOOP];
  assign acc_done = clk_en & psel & penable & pready;
  assign wr_done = acc_done & pwrite;
  assign rd_done = acc_done & ~pwrite;
  assign addr_ok = reg_hit(paddr, `UMCL_OFF_MLC) |
                   reg_hit(paddr, `UMCL_OFF_MLS) |
                   reg_hit(paddr, `UMCL_OFF_IER) |
                   reg_hit(paddr, `UMCL_OFF_IST) |
                   reg_hit(paddr, `UMCL_OFF_IMSK);

  // Line levels as seen by the status logic, order {dcd, ri, dsr, cts}
  always_comb begin
    if (loop_en) begin
      line_now = {modem_line_control_r[`UMCL_MLC_IEN],
                  modem_line_control_r[`UMCL_MLC_OUT],
                  modem_line_control_r[`UMCL_MLC_DTR],
                  modem_line_control_r[`UMCL_MLC_RTS]};
    end else begin
      line_now = ~{carrier_detect_n, ring_indicate_n,
                   data_set_ready_n, clear_to_send_n};
    end
  end

  // Ring reports only its trailing edge: the pin going back high
  always_comb begin
    delta_set = 4'h0;
    delta_set[`UMCL_MLS_DCTS] = line_now[0] ^ line_prev_r[0];
    delta_set[`UMCL_MLS_DDSR] = line_now[1] ^ line_prev_r[1];
    delta_set[`UMCL_MLS_TERI] = line_prev_r[2] & ~line_now[2];
    delta_set[`UMCL_MLS_DDCD] = line_now[3] ^ line_prev_r[3];
  end

  assign modem_line_status = {line_now, delta_r};

  always_comb begin
    irq_events = 4'h0;
    irq_events[`UMCL_IRQ_RXD] = rx_data_event;
    irq_events[`UMCL_IRQ_THRE] = tx_empty_event;
    irq_events[`UMCL_IRQ_LINE] = line_status_event;
    irq_events[`UMCL_IRQ_MODEM] = |delta_set;
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (reg_hit(paddr, `UMCL_OFF_MLC)) begin
      rd_data = {27'h0, modem_line_control_r};
    end else if (reg_hit(paddr, `UMCL_OFF_MLS)) begin
      rd_data = {24'h0, modem_line_status};
    end else if (reg_hit(paddr, `UMCL_OFF_IER)) begin
      rd_data = {28'h0, interrupt_enable_reg_r};
    end else if (reg_hit(paddr, `UMCL_OFF_IST)) begin
      rd_data = {28'h0, irq_status_r};
    end else if (reg_hit(paddr, `UMCL_OFF_IMSK)) begin
      rd_data = {28'h0, irq_mask_r};
    end
  end

  // One wait state so read data and pready both leave flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= ~addr_ok;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_line_control_r <= `UMCL_MLC_RST;
    end else if (wr_done && reg_hit(paddr, `UMCL_OFF_MLC)) begin
      modem_line_control_r <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_reg_r <= `UMCL_IER_RST;
      irq_mask_r <= `UMCL_IMSK_RST;
    end else if (wr_done) begin
      if (reg_hit(paddr, `UMCL_OFF_IER)) begin
        interrupt_enable_reg_r <= pwdata[3:0];
      end
      if (reg_hit(paddr, `UMCL_OFF_IMSK)) begin
        irq_mask_r <= pwdata[3:0];
      end
    end
  end

  // A change in the same cycle as the clearing read survives it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delta_r <= 4'h0;
      line_prev_r <= 4'h0;
    end else if (clk_en) begin
      line_prev_r <= line_now;
      if (rd_done && reg_hit(paddr, `UMCL_OFF_MLS)) begin
        delta_r <= delta_set;
      end else begin
        delta_r <= delta_r | delta_set;
      end
    end
  end

  // Sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= `UMCL_IST_RST;
    end else if (clk_en) begin
      if (wr_done && reg_hit(paddr, `UMCL_OFF_IST)) begin
        irq_status_r <= (irq_status_r & ~pwdata[3:0]) | irq_events;
      end else begin
        irq_status_r <= irq_status_r | irq_events;
      end
    end
  end

  // Enable gates the line in loopback too, so diagnostics see real irqs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart_irq <= 1'b0;
    end else if (clk_en) begin
      uart_irq <= modem_line_control_r[`UMCL_MLC_IEN] &
                  (|(irq_status_r & irq_mask_r &
                     interrupt_enable_reg_r));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_tx_pin <= 1'b1;
      rx_shift_in <= 1'b1;
    end else if (clk_en) begin
      serial_tx_pin <= loop_en ? 1'b1 : tx_shift_out;
      rx_shift_in <= loop_en ? tx_shift_out : serial_rx_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      terminal_ready_n <= 1'b1;
      request_to_send_n <= 1'b1;
    end else if (clk_en) begin
      terminal_ready_n <= loop_en |
                          ~modem_line_control_r[`UMCL_MLC_DTR];
      request_to_send_n <= loop_en |
                           ~modem_line_control_r[`UMCL_MLC_RTS];
    end
  end

endmodule : umcl_top

// File: bench/umcl_modem.sv
// Modem model on the far side of the control lines.
// Assumes the bench chooses which status lines are asserted.
`timescale 1ns/1ps
module umcl_modem (
  input wire logic [3:0] assert_lines,
  input wire logic rx_bit,
  output logic clear_to_send_n,
  output logic data_set_ready_n,
  output logic ring_indicate_n,
  output logic carrier_detect_n,
  output logic serial_rx_pin
);
  // Unasserted lines sit high, as pulled up on a cable
  assign {carrier_detect_n, ring_indicate_n, data_set_ready_n,
    clear_to_send_n} = ~assert_lines;
  assign serial_rx_pin = rx_bit;
endmodule : umcl_modem

// File: bench/umcl_top_chk.sv
// Port checker of the modem control block.
// Assumes clk_en is held high by the bench.
`timescale 1ns/1ps
module umcl_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_rx_pin,
  input wire logic serial_tx_pin,
  input wire logic terminal_ready_n,
  input wire logic request_to_send_n,
  input wire logic tx_shift_out,
  input wire logic rx_shift_in,
  input wire logic uart_irq
);
  logic [4:0] ctl_r;
  // Control bits as left by completed writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_r <= 5'h00;
    else if (psel && penable && pready && pwrite && paddr == 8'h00)
      ctl_r <= pwdata[4:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_tx_mark: assert property ($past(presetn) |-> serial_tx_pin ==
    ($past(ctl_r[4]) | $past(tx_shift_out))) else $error("tx pin");
  a_rx_route: assert property ($past(presetn) |-> rx_shift_in ==
    ($past(ctl_r[4]) ? $past(tx_shift_out) : $past(serial_rx_pin)))
    else $error("rx route");
  a_dtr_pin: assert property ($past(presetn) |-> terminal_ready_n ==
    ($past(ctl_r[4]) | ~$past(ctl_r[0]))) else $error("dtr pin");
  a_rts_pin: assert property ($past(presetn) |-> request_to_send_n ==
    ($past(ctl_r[4]) | ~$past(ctl_r[1]))) else $error("rts pin");
  a_irq_gate: assert property (!$past(ctl_r[3]) |-> !uart_irq)
    else $error("irq while disabled");
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("wait state");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pulse");
  a_err_zero: assert property (pready && paddr > 8'h10 |->
    pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped");
  // Mapped words must never report an error
  a_err_mapped: assert property (pready && paddr <= 8'h10 &&
    paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped error");
endmodule : umcl_chk

// File: bench/umcl_top_tb.sv
// Bench of the modem control block: APB master, modem model, scoreboard.
// Assumes one wait state per APB transfer; clk_en stays high.
`timescale 1ns/1ps
module umcl_top_tb;
  logic pclk, presetn, psel, penable, pwrite, tx_shift_out, rx_bit;
  logic pready, pslverr, serial_rx_pin, serial_tx_pin, rx_shift_in;
  logic uart_irq, terminal_ready_n, request_to_send_n;
  logic clear_to_send_n, data_set_ready_n, ring_indicate_n, carrier_detect_n;
  logic [7:0] paddr, r;
  logic [31:0] pwdata, prdata;
  logic [3:0] lines, v;
  logic [2:0] ev;
  logic [31:0] q[$];
  int err_count = 0;
  int n_compared = 0;
  umcl_top umcl_top_i (.*, .clk_en(1'b1), .rx_data_event(ev[0]),
    .tx_empty_event(ev[1]), .line_status_event(ev[2]));
  umcl_modem umcl_modem_i (.*, .assert_lines(lines));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      final_report();
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(0, a, 32'h0);
  endtask : rd
  task automatic irq(input logic e);
    repeat (2) @(posedge pclk);
    chk({31'h0, e}, {31'h0, uart_irq});
  endtask : irq
  // Scoreboard side: each read answer meets the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) chk(q.pop_front(), prdata);
  end
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    r <= lfsr(r);
    tx_shift_out <= r[0];
    rx_bit <= r[1];
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; lines = 4'h0; ev = 3'h0; r = 8'h46;
    tx_shift_out = 1; rx_bit = 1;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int a = 0; a <= 16; a += 4) rd(a[7:0], 32'h0);
    v = r[3:0];
    wr(8'h00, {24'h0, 4'he, v});
    rd(8'h00, {28'h0, v});
    wr(8'h14, 32'hff);
    rd(8'h20, 32'h0);
    $display("test 1 done");
    wr(8'h00, 32'h0);
    lines <= 4'hf;
    rd(8'h04, 32'hfb);
    rd(8'h04, 32'hf0);
    lines <= 4'hb;
    rd(8'h04, 32'hb4);
    $display("test 2 done");
    wr(8'h00, 32'h1f);
    lines <= 4'h0;
    rd(8'h04, 32'hf0);
    wr(8'h00, 32'h10);
    rd(8'h04, 32'h0f);
    $display("test 3 done");
    wr(8'h00, 32'h18);
    wr(8'h0c, 32'hf);
    wr(8'h08, 32'hf);
    wr(8'h10, 32'hf);
    ev <= 3'h7;
    @(posedge pclk);
    ev <= 3'h0;
    rd(8'h0c, 32'h7);
    irq(1);
    wr(8'h10, 32'h0);
    irq(0);
    wr(8'h10, 32'hf);
    wr(8'h08, 32'h0);
    irq(0);
    wr(8'h08, 32'hf);
    wr(8'h00, 32'h10);
    irq(0);
    wr(8'h0c, 32'hf);
    wr(8'h00, 32'h18);
    wr(8'h0c, 32'hf);
    irq(0);
    $display("test 4 done");
    final_report();
  end
endmodule : umcl_top_tb
bind umcl_top umcl_chk umcl_chk_i (.*);
